// ==== logic/rtc_radial_carriage.sv ====
// Radial actuator handover, excursion measurement and carriage control
`timescale 1ns/100ps
`default_nettype none
module rtc_radial_carriage import rtc_pkg::*; #(
  parameter int unsigned MAX_CROSS = 16,
  parameter int unsigned EXC_LIMIT = 60
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_squared_tracking_error,
  input wire logic i_hf_present_detect,
  input wire logic i_cmp_normal,
  input wire logic i_cmp_inverted,
  input wire logic i_track_loss_flag,
  input wire logic i_rev_pulse,
  input wire logic i_speed_ok,
  input wire logic i_carriage_position_sense_hi,
  input wire logic i_carriage_position_sense_lo,
  input wire logic i_audio_disc_select,
  input wire logic i_run,
  input wire logic i_load,
  input wire logic i_unload,
  input wire logic i_fast,
  output logic o_radial_open_loop_hold,
  output logic o_loop_bandwidth_select,
  output logic o_error_hold,
  output logic o_dither_phase_audio,
  output logic o_ramp_start,
  output logic o_carriage_ramp_enable,
  output logic o_carriage_direction,
  output logic o_carriage_speed_a,
  output logic o_carriage_speed_b,
  output logic o_spin_abort,
  output logic signed [MT_W:0] o_excursion
);

  rtc_pins_t pin_s1_ff;
  rtc_pins_t pin_s2_ff;
  rtc_pins_t pin_prv_ff;
  rtc_pins_t pins_raw;

  assign pins_raw = '{ste: i_squared_tracking_error, hf_present_detect: i_hf_present_detect,
                      cmpn: i_cmp_normal, cmpi: i_cmp_inverted,
                      loss: i_track_loss_flag, rev: i_rev_pulse, spd: i_speed_ok,
                      phi: i_carriage_position_sense_hi,
                      plo: i_carriage_position_sense_lo};

  // Stage one feeds stage two only
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_prv_ff <= '0;
    end else begin
      pin_s1_ff <= pins_raw;
      pin_s2_ff <= pin_s1_ff;
      pin_prv_ff <= pin_s2_ff;
    end
  end

  wire hfd_rise = pin_s2_ff.hf_present_detect & ~pin_prv_ff.hf_present_detect;
  wire rev_edge = pin_s2_ff.rev & ~pin_prv_ff.rev;
  // Level one cycle before the HF rise; high means inward
  wire cross_in = hfd_rise & pin_prv_ff.ste;
  wire cross_out = hfd_rise & ~pin_prv_ff.ste;

  // Revolution timing
  logic [REV_W-1:0] rev_cnt_ff;
  logic [REV_W-1:0] rev_per_ff;
  logic rev_seen_ff;
  wire [REV_W-1:0] rev_half = rev_per_ff >> 1;
  wire samp_pt = rev_seen_ff & ((rev_cnt_ff == '0) | (rev_cnt_ff == rev_half));

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rev_cnt_ff <= '0;
      rev_per_ff <= '0;
      rev_seen_ff <= 1'b0;
    end else if (rev_edge) begin
      rev_cnt_ff <= '0;
      rev_per_ff <= rev_cnt_ff;
      rev_seen_ff <= 1'b1;
    end else if (rev_cnt_ff != REV_MAX) begin
      rev_cnt_ff <= rev_cnt_ff + 1'b1;
    end
  end

  // Crossing count and the parallel-running gap within a turn
  logic [7:0] cross_cnt_ff;
  logic [REV_W-1:0] out_pos_ff;
  logic [REV_W-1:0] in_pos_ff;
  logic gap_open_ff;
  logic gap_done_ff;
  logic [REV_W-1:0] hand_pos_ff;
  logic hand_vld_ff;
  wire [REV_W:0] pos_sum = {1'b0, out_pos_ff} + {1'b0, in_pos_ff};

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cross_cnt_ff <= '0;
      out_pos_ff <= '0;
      in_pos_ff <= '0;
      gap_open_ff <= 1'b0;
      gap_done_ff <= 1'b0;
      hand_pos_ff <= '0;
      hand_vld_ff <= 1'b0;
    end else if (rev_edge) begin
      cross_cnt_ff <= '0;
      gap_open_ff <= 1'b0;
      gap_done_ff <= 1'b0;
      hand_vld_ff <= gap_done_ff;
      // Midpoint of the gap recurs at the same phase next turn
      if (gap_done_ff) begin
        hand_pos_ff <= pos_sum[REV_W:1];
      end
    end else begin
      if (hfd_rise && cross_cnt_ff != CROSS_MAX) begin
        cross_cnt_ff <= cross_cnt_ff + 1'b1;
      end
      if (cross_out) begin
        out_pos_ff <= rev_cnt_ff;
        gap_open_ff <= 1'b1;
        gap_done_ff <= 1'b0;
      end else if (cross_in && gap_open_ff) begin
        in_pos_ff <= rev_cnt_ff;
        gap_open_ff <= 1'b0;
        gap_done_ff <= 1'b1;
      end
    end
  end

  // Main sequence
  rtc_st_t st_ff;
  rtc_st_t nxt_st;
  logic lock_ff;
  wire too_many = rev_edge & (cross_cnt_ff > 8'(MAX_CROSS));
  wire at_hand = hand_vld_ff & pin_s2_ff.spd & (rev_cnt_ff == hand_pos_ff);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (i_run) nxt_st = ST_SPIN;
      end
      ST_SPIN: begin
        if (!i_run) nxt_st = ST_IDLE;
        else if (too_many) nxt_st = ST_ABORT;
        else if (rev_edge && cross_cnt_ff != '0) nxt_st = ST_ACQ;
      end
      ST_ACQ: begin
        if (!i_run) nxt_st = ST_IDLE;
        else if (too_many) nxt_st = ST_ABORT;
        else if (at_hand) nxt_st = ST_TRK;
      end
      ST_TRK: begin
        if (!i_run) nxt_st = ST_IDLE;
      end
      ST_ABORT: begin
        if (!i_run) nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_ff <= ST_IDLE;
      lock_ff <= 1'b0;
      o_radial_open_loop_hold <= 1'b1;
      o_loop_bandwidth_select <= 1'b0;
      o_error_hold <= 1'b0;
      o_dither_phase_audio <= 1'b0;
      o_spin_abort <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      // Locked at the first revolution pulse edge after the loop closes
      if (nxt_st != ST_TRK) lock_ff <= 1'b0;
      else if (rev_edge) lock_ff <= 1'b1;
      o_radial_open_loop_hold <= (nxt_st != ST_TRK);
      // Startup bandwidth returns on the same edge as the loop opens
      o_loop_bandwidth_select <= lock_ff & (nxt_st == ST_TRK);
      o_error_hold <= pin_s2_ff.loss & (nxt_st == ST_TRK);
      o_dither_phase_audio <= i_audio_disc_select;
      o_spin_abort <= (nxt_st == ST_ABORT);
    end
  end

  // Excursion measurement against the self-started ramp
  logic meas_ff;
  logic [MT_W-1:0] mt_ff;
  logic [MT_W-1:0] tn_ff;
  logic [MT_W-1:0] ti_ff;
  logic gotn_ff;
  logic goti_ff;
  logic signed [MT_W:0] dprev_ff;
  logic have_prev_ff;
  logic mean_vld_ff;
  wire meas_go = samp_pt & ~meas_ff & (st_ff == ST_TRK);
  wire meas_end = meas_ff & (mt_ff == RAMP_LAST);
  // Difference cancels the reference level of both copies
  wire signed [MT_W:0] dcur = $signed({1'b0, tn_ff}) - $signed({1'b0, ti_ff});
  wire signed [MT_W+1:0] dsum = {dprev_ff[MT_W], dprev_ff} + {dcur[MT_W], dcur};
  wire signed [MT_W:0] dmean = dsum[MT_W+1:1];
  wire [MT_W:0] mag = o_excursion[MT_W] ? (MT_W+1)'(0) - o_excursion : o_excursion;
  wire exc_hit = mean_vld_ff & (mag >= (MT_W+1)'(EXC_LIMIT));

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meas_ff <= 1'b0;
      mt_ff <= '0;
      tn_ff <= '0;
      ti_ff <= '0;
      gotn_ff <= 1'b0;
      goti_ff <= 1'b0;
      dprev_ff <= '0;
      have_prev_ff <= 1'b0;
      mean_vld_ff <= 1'b0;
      o_excursion <= '0;
      o_ramp_start <= 1'b0;
    end else begin
      o_ramp_start <= meas_go;
      mean_vld_ff <= 1'b0;
      if (st_ff != ST_TRK) have_prev_ff <= 1'b0;
      if (meas_go) begin
        meas_ff <= 1'b1;
        mt_ff <= '0;
        // No comparator edge reads as full scale
        tn_ff <= RAMP_FULL;
        ti_ff <= RAMP_FULL;
        gotn_ff <= 1'b0;
        goti_ff <= 1'b0;
      end else if (meas_ff) begin
        mt_ff <= mt_ff + 1'b1;
        if (pin_s2_ff.cmpn && !gotn_ff) begin
          tn_ff <= mt_ff;
          gotn_ff <= 1'b1;
        end
        if (pin_s2_ff.cmpi && !goti_ff) begin
          ti_ff <= mt_ff;
          goti_ff <= 1'b1;
        end
        if (meas_end) begin
          meas_ff <= 1'b0;
          dprev_ff <= dcur;
          have_prev_ff <= 1'b1;
          if (have_prev_ff) begin
            o_excursion <= dmean;
            mean_vld_ff <= 1'b1;
          end
        end
      end
    end
  end

  // Carriage motor
  rtc_cst_t cst_ff;
  rtc_cst_t nxt_cst;
  logic [1:0] pos_ref_ff;
  logic cdir_ff;
  wire loading = i_load | i_unload;
  wire [1:0] pos_now = {pin_s2_ff.phi, pin_s2_ff.plo};
  // Live sign on the entry edge, frozen while the pickup moves
  wire dir_now = (cst_ff == C_IDLE) ? o_excursion[MT_W] : cdir_ff;

  always_comb begin
    nxt_cst = cst_ff;
    unique case (cst_ff)
      C_IDLE: begin
        if (loading) nxt_cst = C_LOAD;
        else if (nxt_st == ST_TRK && exc_hit) nxt_cst = C_PLAY;
      end
      C_PLAY: begin
        // Pickup stepped once the position sense pattern moves
        if (pos_now != pos_ref_ff || nxt_st != ST_TRK) nxt_cst = C_IDLE;
      end
      C_LOAD: begin
        if (!loading) nxt_cst = C_IDLE;
      end
      default: nxt_cst = C_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cst_ff <= C_IDLE;
      pos_ref_ff <= '0;
      cdir_ff <= 1'b0;
      o_carriage_ramp_enable <= 1'b0;
      o_carriage_direction <= 1'b0;
      o_carriage_speed_a <= 1'b0;
      o_carriage_speed_b <= 1'b0;
    end else begin
      cst_ff <= nxt_cst;
      if (cst_ff == C_IDLE) begin
        pos_ref_ff <= pos_now;
        cdir_ff <= o_excursion[MT_W];
      end
      o_carriage_ramp_enable <= (nxt_cst == C_PLAY);
      o_carriage_direction <= (nxt_cst == C_LOAD) ? i_unload : dir_now;
      o_carriage_speed_a <= (nxt_cst == C_LOAD);
      o_carriage_speed_b <= (nxt_cst == C_LOAD) & i_fast;
    end
  end

endmodule : rtc_radial_carriage
`default_nettype wire

// ==== logic/rtc_pkg.sv ====
// Constants and types for the radial tracking and carriage controller
`default_nettype none
package rtc_pkg;
  localparam int unsigned REV_W = 24;
  localparam int unsigned MT_W = 8;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RAMP_TIME_NS = 20000;
  localparam int unsigned RAMP_CYC = RAMP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [MT_W-1:0] RAMP_LAST = MT_W'(RAMP_CYC - 1);
  localparam logic [MT_W-1:0] RAMP_FULL = MT_W'(RAMP_CYC);
  localparam logic [REV_W-1:0] REV_MAX = {REV_W{1'b1}};
  localparam logic [7:0] CROSS_MAX = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SPIN = 3'b001,
    ST_ACQ = 3'b010,
    ST_TRK = 3'b011,
    ST_ABORT = 3'b100
  } rtc_st_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_PLAY = 2'b01,
    C_LOAD = 2'b10
  } rtc_cst_t;

  // Every asynchronous pin, carried as one word through the synchroniser
  typedef struct packed {
    logic ste;
    logic hf_present_detect;
    logic cmpn;
    logic cmpi;
    logic loss;
    logic rev;
    logic spd;
    logic phi;
    logic plo;
  } rtc_pins_t;
endpackage : rtc_pkg
`default_nettype wire

// ==== sim/rtc_radial_carriage_assertions.sv ====
// Port checks for the radial carriage controller
`timescale 1ns/100ps
`default_nettype none
module rtc_radial_carriage_assertions (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic i_unload,
  input wire logic i_audio_disc_select,
  input wire logic o_radial_open_loop_hold,
  input wire logic o_loop_bandwidth_select,
  input wire logic o_error_hold,
  input wire logic o_dither_phase_audio,
  input wire logic o_ramp_start,
  input wire logic o_carriage_ramp_enable,
  input wire logic o_carriage_direction,
  input wire logic o_carriage_speed_a,
  input wire logic o_spin_abort
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  AST_DITHER: assert property (
    !$past(i_srst) |-> o_dither_phase_audio == $past(i_audio_disc_select))
    else $error("dither phase lag");
  AST_RAMP_PULSE: assert property (o_ramp_start |=> !o_ramp_start [*8])
    else $error("ramp start too long");
  AST_OPEN_IDLE: assert property (!i_run |=> o_radial_open_loop_hold)
    else $error("loop closed without run");
  AST_LOCKED: assert property (
    $rose(o_loop_bandwidth_select) |-> !o_radial_open_loop_hold) else $error("early lock");
  AST_LOSS: assert property ($rose(o_error_hold) |-> !o_radial_open_loop_hold)
    else $error("error hold while open");
  AST_CAR_PLAY: assert property (
    $rose(o_carriage_ramp_enable) |-> !o_radial_open_loop_hold) else $error("carriage off");
  AST_LOAD_RAMP: assert property (o_carriage_speed_a |-> !o_carriage_ramp_enable)
    else $error("ramp during load");
  AST_LOAD_DIR: assert property (
    o_carriage_speed_a && !$past(i_srst) |-> o_carriage_direction == $past(i_unload))
    else $error("load direction");
  AST_ABORT_OPEN: assert property (o_spin_abort |-> o_radial_open_loop_hold)
    else $error("loop closed during abort");
  cover property ($fell(o_radial_open_loop_hold));
  cover property ($rose(o_carriage_ramp_enable));
  cover property (o_ramp_start);
endmodule : rtc_radial_carriage_assertions
bind rtc_radial_carriage rtc_radial_carriage_assertions rtc_chk (.*);
`default_nettype wire

// ==== sim/rtc_far.sv ====
// Far side: eccentric crossings, tacho and offset comparators
`timescale 1ns/100ps
`default_nettype none
module rtc_far (
  input wire logic i_mclk,
  input wire logic i_ramp,
  input wire logic [3:0] i_n,
  input wire logic [7:0] i_tn,
  input wire logic [7:0] i_ti,
  output logic o_rev,
  output logic o_hfd,
  output logic o_ste,
  output logic o_cmpn,
  output logic o_cmpi
);
  int ph = 0;
  int rc = 999;
  always @(posedge i_mclk) begin
    ph <= (ph == 1999) ? 0 : ph + 1;
    rc <= i_ramp ? 0 : rc + 1;
  end
  // Outward crossings early in a turn, inward late, so the gap sits mid-turn
  function automatic logic hit(input int p, input int b);
    return p >= b && p < b + 40 * i_n && (p - b) % 40 < 4;
  endfunction : hit
  assign o_rev = ph < 10;
  assign o_ste = ph >= 1000;
  assign o_hfd = hit(ph, 100) || hit(ph, 1100);
  // Low again after the ramp, as a comparator with no ramp would be
  assign o_cmpn = rc >= i_tn && rc < 220;
  assign o_cmpi = rc >= i_ti && rc < 220;
endmodule : rtc_far
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the radial carriage controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_run = 1'b0, i_load = 1'b0, i_unload = 1'b0, i_fast = 1'b0, i_speed_ok = 1'b0;
  logic i_audio_disc_select = 1'b0, i_track_loss_flag = 1'b0;
  logic i_carriage_position_sense_hi = 1'b0, i_carriage_position_sense_lo = 1'b0;
  logic [3:0] ncross = 4'h9;
  logic [7:0] tn = 8'h96, ti = 8'h1E;
  wire logic i_squared_tracking_error, i_hf_present_detect, i_rev_pulse;
  wire logic i_cmp_normal, i_cmp_inverted, o_radial_open_loop_hold, o_loop_bandwidth_select;
  wire logic o_error_hold, o_dither_phase_audio, o_ramp_start, o_carriage_ramp_enable;
  wire logic o_carriage_direction, o_carriage_speed_a, o_carriage_speed_b, o_spin_abort;
  wire logic signed [rtc_pkg::MT_W:0] o_excursion;
  int err_count = 0;
  int checks = 0;
  // Load, unload, fast, audio; then speed a, speed b, direction, dither
  logic [7:0] rows [6] = '{8'h88, 8'hBD, 8'h5B, 8'h6E, 8'h88, 8'h00};
  rtc_radial_carriage rtc_radial_carriage_inst (.*);
  rtc_far rtc_far_inst (.i_mclk(i_mclk), .i_ramp(o_ramp_start), .i_n(ncross), .i_tn(tn),
    .i_ti(ti), .o_rev(i_rev_pulse), .o_hfd(i_hf_present_detect),
    .o_ste(i_squared_tracking_error), .o_cmpn(i_cmp_normal), .o_cmpi(i_cmp_inverted));
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  task automatic at_ph(input int p);
    do @(posedge i_mclk); while (rtc_far_inst.ph != p);
    #1;
  endtask : at_ph
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (40000) @(posedge i_mclk);
    err_count++;
    give_verdict();
  end
  initial begin
    step(4);
    i_srst = 1'b0;
    step(1);
    chk({o_radial_open_loop_hold, o_carriage_ramp_enable, o_carriage_speed_a, o_spin_abort},
      12'h008);
    for (int k = 0; k < 6; k++) begin
      {i_load, i_unload, i_fast, i_audio_disc_select} = rows[k][7:4];
      step(4);
      chk({o_carriage_speed_a, o_carriage_speed_b, o_carriage_direction, o_dither_phase_audio},
        rows[k][3:0]);
    end
    // Start just after a tacho edge so the first counted turn is whole
    at_ph(20);
    i_run = 1'b1;
    repeat (3) at_ph(50);
    chk({o_spin_abort, o_radial_open_loop_hold}, 12'h003);
    i_srst = 1'b1;
    ncross = 4'h3;
    step(4);
    i_srst = 1'b0;
    repeat (3) at_ph(900);
    chk(o_radial_open_loop_hold, 12'h001);
    i_speed_ok = 1'b1;
    at_ph(600);
    chk(o_radial_open_loop_hold, 12'h001);
    at_ph(700);
    chk({o_radial_open_loop_hold, o_loop_bandwidth_select}, 12'h000);
    at_ph(500);
    chk({o_loop_bandwidth_select, o_carriage_ramp_enable, o_carriage_direction, o_excursion},
      12'hC78);
    i_carriage_position_sense_hi = 1'b1;
    tn = 8'h1E;
    ti = 8'h96;
    step(2);
    chk(o_carriage_ramp_enable, 12'h001);
    step(4);
    chk(o_carriage_ramp_enable, 12'h000);
    i_track_loss_flag = 1'b1;
    step(6);
    chk(o_error_hold, 12'h001);
    i_track_loss_flag = 1'b0;
    at_ph(3);
    chk(o_ramp_start, 12'h001);
    step(1);
    chk(o_ramp_start, 12'h000);
    at_ph(204);
    chk({o_carriage_ramp_enable, o_carriage_direction}, 12'h003);
    at_ph(500);
    chk({o_error_hold, o_carriage_ramp_enable, o_carriage_direction, o_excursion},
      12'h788);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
